// File: rtl/std_timer_pkg.sv
package std_timer_pkg;

    // Register indices (word addresses, byte address = index * 4)
    localparam logic [2:0] REG_CTRL_CLOCK_RUN   = 3'h0;
    localparam logic [2:0] REG_CTRL_MODE_OUTPUT = 3'h1;
    localparam logic [2:0] REG_COUNT_LOW        = 3'h2;
    localparam logic [2:0] REG_COUNT_HIGH       = 3'h3;
    localparam logic [2:0] REG_MATCH_A_LOW      = 3'h4;
    localparam logic [2:0] REG_MATCH_A_HIGH     = 3'h5;
    localparam logic [2:0] REG_EVENT_STATUS     = 3'h6;
    localparam int         ADDR_LSB             = 2;

    // Control register 0 fields
    localparam int CR0_PAUSE   = 7;
    localparam int CR0_CLK_HI  = 6;
    localparam int CR0_CLK_LO  = 4;
    localparam int CR0_RUN     = 3;
    localparam int CR0_PER_HI  = 2;
    localparam int CR0_PER_LO  = 0;

    // Control register 1 fields
    localparam int CR1_MODE_HI = 7;
    localparam int CR1_MODE_LO = 6;
    localparam int CR1_IO_HI   = 5;
    localparam int CR1_IO_LO   = 4;
    localparam int CR1_INIT    = 3;
    localparam int CR1_POL     = 2;
    localparam int CR1_CLR_SEL = 0;

    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int         CNT_W      = 10;
    localparam int         PER_W      = 3;

    // Modes
    localparam logic [1:0] MODE_COMPARE = 2'h0;
    localparam logic [1:0] MODE_CAPTURE = 2'h1;
    localparam logic [1:0] MODE_PWM     = 2'h2;
    localparam logic [1:0] MODE_TIMER   = 2'h3;

    // Pin action codes
    localparam logic [1:0] ACT_NONE   = 2'h0;
    localparam logic [1:0] ACT_LOW    = 2'h1;
    localparam logic [1:0] ACT_HIGH   = 2'h2;
    localparam logic [1:0] ACT_TOGGLE = 2'h3;
    localparam logic [1:0] ACT_RISE   = 2'h0;
    localparam logic [1:0] ACT_FALL   = 2'h1;
    localparam logic [1:0] ACT_SINGLE = 2'h3;

    // Clock select codes
    localparam logic [2:0] CK_SYS_DIV4 = 3'h0;
    localparam logic [2:0] CK_SYS      = 3'h1;
    localparam logic [2:0] CK_H_DIV16  = 3'h2;
    localparam logic [2:0] CK_H_DIV64  = 3'h3;
    localparam logic [2:0] CK_SUB_A    = 3'h4;
    localparam logic [2:0] CK_SUB_B    = 3'h5;
    localparam logic [2:0] CK_EXT_RISE = 3'h6;
    localparam logic [2:0] CK_EXT_FALL = 3'h7;

    localparam logic [7:0] DIV_SYS  = 8'h04;
    localparam logic [7:0] DIV_H16  = 8'h10;
    localparam logic [7:0] DIV_H64  = 8'h40;

endpackage

// File: rtl/std_timer_edge.sv
`timescale 1ns/10ps
// Two-stage synchroniser with rise and fall detection on the settled stage
module std_timer_edge (
    // Clock and reset
    input  wire logic SYS_CLK_I,
    input  wire logic RESET_I,
    // Pin and edges
    input  wire logic pin_i,
    output logic      level_o,
    output logic      rise_o,
    output logic      fall_o
);
    logic meta;
    logic sync;
    logic prev;

    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            meta <= 1'b0;
            sync <= 1'b0;
            prev <= 1'b0;
        end else begin
            meta <= pin_i;
            sync <= meta;
            prev <= sync;
        end
    end

    assign level_o = sync;
    assign rise_o  = sync & ~prev;
    assign fall_o  = ~sync & prev;
endmodule

// File: rtl/standard_timer.sv
// The implementer's own choices: the Wishbone register port and the address map.
`timescale 1ns/10ps
module standard_timer
    import std_timer_pkg::*;
#(
    parameter int CNT_WIDTH = CNT_W
) (
    // Clock and reset
    input  wire logic        SYS_CLK_I,
    input  wire logic        RESET_I,
    // Wishbone slave
    input  wire logic        CYC_I,
    input  wire logic        STB_I,
    input  wire logic        WE_I,
    input  wire logic [3:0]  SEL_I,
    input  wire logic [4:0]  ADR_I,
    input  wire logic [31:0] DAT_I,
    output logic [31:0]      DAT_O,
    output logic             ACK_O,
    output logic             ERR_O,
    // Other clock sources
    input  wire logic        H_CLK_TICK_I,
    input  wire logic        SUB_CLK_TICK_I,
    // Pins
    input  wire logic        EXT_CLOCK_PIN_I,
    input  wire logic        CAPTURE_PIN_I,
    output logic             TIMER_OUTPUT_PIN_O,
    // Events
    output logic             MATCH_A_REQ_O,
    output logic             MATCH_P_REQ_O,
    output logic             CAPTURE_EVENT_O
);

    if (CNT_WIDTH != CNT_W) begin : g_width_check
        $error("counter width must be ten");
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0]           ctrl_clock_run;
    logic [7:0]           ctrl_mode_output;
    logic [CNT_WIDTH-1:0] match_a_value;
    logic [CNT_WIDTH-1:0] count;
    logic [CNT_WIDTH-1:0] capture_value;
    logic [7:0]           low_buffer;
    logic                 run_prev;
    logic                 out_level;
    logic                 pulse_active;
    logic [7:0]           pre_div;
    logic                 ack;
    logic [31:0]          rd_data;

    wire       count_pause        = ctrl_clock_run[CR0_PAUSE];
    wire [2:0] clock_select       = ctrl_clock_run[CR0_CLK_HI:CR0_CLK_LO];
    wire       timer_run          = ctrl_clock_run[CR0_RUN];
    wire [2:0] period_match_field = ctrl_clock_run[CR0_PER_HI:CR0_PER_LO];
    wire [1:0] mode               = ctrl_mode_output[CR1_MODE_HI:CR1_MODE_LO];
    wire [1:0] pin_action_select  = ctrl_mode_output[CR1_IO_HI:CR1_IO_LO];
    wire       output_initial_level = ctrl_mode_output[CR1_INIT];
    wire       out_polarity       = ctrl_mode_output[CR1_POL];
    wire       clear_source_select = ctrl_mode_output[CR1_CLR_SEL];

    ////////////////////////////////////////////////////////////////////////
    // Bus decode
    // An error answer also blocks a second take while the master still holds
    wire       req      = CYC_I & STB_I & ~ack & ~ERR_O;
    wire [2:0] reg_idx  = ADR_I[ADDR_LSB+2:ADDR_LSB];
    wire       mapped   = (ADR_I[1:0] == 2'h0) && (reg_idx <= REG_EVENT_STATUS);
    wire       lane0    = SEL_I[0];
    wire       wr       = req & WE_I & mapped & lane0;
    wire       rd       = req & ~WE_I & mapped;
    wire       wr_cr0   = wr && (reg_idx == REG_CTRL_CLOCK_RUN);
    wire       wr_cr1   = wr && (reg_idx == REG_CTRL_MODE_OUTPUT);
    wire       wr_a_lo  = wr && (reg_idx == REG_MATCH_A_LOW);
    wire       wr_a_hi  = wr && (reg_idx == REG_MATCH_A_HIGH);
    wire       rd_c_hi  = rd && (reg_idx == REG_COUNT_HIGH);
    wire       rd_a_hi  = rd && (reg_idx == REG_MATCH_A_HIGH);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic ck_rise, ck_fall;
    logic cap_level, cap_rise, cap_fall;

    std_timer_edge u_ck_edge (
        .SYS_CLK_I (SYS_CLK_I),
        .RESET_I   (RESET_I),
        .pin_i     (EXT_CLOCK_PIN_I),
        .level_o   (),
        .rise_o    (ck_rise),
        .fall_o    (ck_fall)
    );

    std_timer_edge u_cap_edge (
        .SYS_CLK_I (SYS_CLK_I),
        .RESET_I   (RESET_I),
        .pin_i     (CAPTURE_PIN_I),
        .level_o   (cap_level),
        .rise_o    (cap_rise),
        .fall_o    (cap_fall)
    );

    ////////////////////////////////////////////////////////////////////////
    // Clock source selection
    wire [7:0] div_limit = (clock_select == CK_SYS_DIV4) ? DIV_SYS :
                           (clock_select == CK_H_DIV16)  ? DIV_H16 : DIV_H64;
    wire       div_src   = (clock_select == CK_SYS_DIV4) ? 1'b1 : H_CLK_TICK_I;
    wire       div_wrap  = div_src && (pre_div == div_limit - 8'h01);
    wire [7:0] next_pre_div = !div_src ? pre_div :
                              div_wrap ? 8'h00 : pre_div + 8'h01;

    logic tick_src;
    always_comb begin
        case (clock_select)
            CK_SYS_DIV4, CK_H_DIV16, CK_H_DIV64: tick_src = div_wrap;
            CK_SYS:                              tick_src = 1'b1;
            CK_SUB_A, CK_SUB_B:                  tick_src = SUB_CLK_TICK_I;
            CK_EXT_RISE:                         tick_src = ck_rise;
            CK_EXT_FALL:                         tick_src = ck_fall;
            default:                             tick_src = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Counter and comparators
    wire run_start = timer_run & ~run_prev;
    wire tick      = timer_run & ~count_pause & tick_src;
    wire [CNT_WIDTH-1:0] cnt_max = {CNT_WIDTH{1'b1}};

    wire match_a   = tick && (count == match_a_value);
    wire p_zero    = (period_match_field == 3'h0);
    // Period is field*128 counter ticks (1024 for field 0), so match on the last count before the boundary
    wire [PER_W-1:0] per_last = period_match_field - 3'h1;
    wire match_p   = tick && (p_zero ? (count == cnt_max)
                     : (count[CNT_WIDTH-1:CNT_WIDTH-PER_W] == per_last
                        && count[CNT_WIDTH-PER_W-1:0] == cnt_max[CNT_WIDTH-PER_W-1:0]));
    wire pwm_mode  = (mode == MODE_PWM);
    wire clr_a     = pwm_mode ? 1'b0 : clear_source_select;
    wire clear_hit = clr_a ? match_a : match_p;
    wire p_req     = match_p & ~clr_a;
    wire single    = pwm_mode && (pin_action_select == ACT_SINGLE);

    wire [CNT_WIDTH-1:0] next_count =
        run_start ? '0 :
        clear_hit ? '0 :
        tick      ? count + 1'b1 : count;

    // Output pin behaviour
    logic next_out;
    always_comb begin
        next_out = out_level;
        if (run_start) begin
            next_out = output_initial_level;
        end else if (mode == MODE_COMPARE && match_a) begin
            case (pin_action_select)
                ACT_LOW:    next_out = 1'b0;
                ACT_HIGH:   next_out = 1'b1;
                ACT_TOGGLE: next_out = ~out_level;
                default:    next_out = out_level;
            endcase
        end else if (pwm_mode) begin
            case (pin_action_select)
                ACT_NONE:   next_out = ~output_initial_level;
                2'h1:       next_out = output_initial_level;
                2'h2:       next_out = (next_count < match_a_value)
                                       ? output_initial_level : ~output_initial_level;
                default:    next_out = pulse_active ? output_initial_level
                                                    : ~output_initial_level;
            endcase
        end
    end

    // Single pulse: pin edge triggers, comparator A match ends
    wire next_pulse = (single && ck_rise && timer_run) ? 1'b1 :
                      (match_a || !timer_run) ? 1'b0 : pulse_active;

    // Capture edge
    logic cap_edge;
    always_comb begin
        case (pin_action_select)
            ACT_RISE: cap_edge = cap_rise;
            ACT_FALL: cap_edge = cap_fall;
            default:  cap_edge = cap_rise | cap_fall;
        endcase
    end
    wire capture = (mode == MODE_CAPTURE) && timer_run && cap_edge;

    ////////////////////////////////////////////////////////////////////////
    // Byte buffer
    wire [7:0] next_buffer = wr_a_lo ? DAT_I[7:0] :
                             rd_c_hi ? count[7:0] :
                             rd_a_hi ? match_a_value[7:0] : low_buffer;

    ////////////////////////////////////////////////////////////////////////
    // Read mux
    always_comb begin
        rd_data = 32'h0000_0000;
        case (reg_idx)
            REG_CTRL_CLOCK_RUN:   rd_data[7:0] = ctrl_clock_run;
            REG_CTRL_MODE_OUTPUT: rd_data[7:0] = ctrl_mode_output;
            REG_COUNT_LOW:        rd_data[7:0] = low_buffer;
            REG_COUNT_HIGH:       rd_data[1:0] = count[CNT_WIDTH-1:8];
            REG_MATCH_A_LOW:      rd_data[7:0] = low_buffer;
            REG_MATCH_A_HIGH:     rd_data[1:0] = match_a_value[CNT_WIDTH-1:8];
            REG_EVENT_STATUS:     rd_data[CNT_WIDTH:0] = {cap_level, capture_value};
            default:              rd_data = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // State
    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            ctrl_clock_run   <= CTRL_RESET;
            ctrl_mode_output <= CTRL_RESET;
            match_a_value    <= '0;
            count            <= '0;
            capture_value    <= '0;
            low_buffer       <= 8'h00;
            run_prev         <= 1'b0;
            out_level        <= 1'b0;
            pulse_active     <= 1'b0;
            pre_div          <= 8'h00;
        end else begin
            if (wr_cr0) ctrl_clock_run <= DAT_I[7:0];
            if (wr_cr1) ctrl_mode_output <= DAT_I[7:0];
            if (wr_a_hi) match_a_value <= {DAT_I[1:0], low_buffer};
            if (capture) capture_value <= count;
            count        <= next_count;
            low_buffer   <= next_buffer;
            run_prev     <= timer_run;
            out_level    <= next_out;
            pulse_active <= next_pulse;
            pre_div      <= next_pre_div;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            ack           <= 1'b0;
            DAT_O         <= 32'h0000_0000;
            ERR_O         <= 1'b0;
            MATCH_A_REQ_O <= 1'b0;
            MATCH_P_REQ_O <= 1'b0;
            CAPTURE_EVENT_O <= 1'b0;
        end else begin
            ack           <= req & mapped;
            ERR_O         <= req & ~mapped;
            DAT_O         <= rd ? rd_data : 32'h0000_0000;
            MATCH_A_REQ_O <= match_a | (capture & cap_edge);
            MATCH_P_REQ_O <= p_req;
            CAPTURE_EVENT_O <= capture;
        end
    end

    assign ACK_O              = ack;
    assign TIMER_OUTPUT_PIN_O = (mode == MODE_TIMER) ? 1'b0 : out_level ^ out_polarity;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    sequence s_run_rise;
        !run_prev && timer_run;
    endsequence

    a_run_clears_count: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
        s_run_rise |=> (count == '0))
        else $error("count not cleared on run start");

    a_stop_holds_count: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
        (!timer_run && !run_start) |=> (count == $past(count)))
        else $error("count moved while stopped");

    a_pause_holds: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
        (count_pause && !run_start) |=> $stable(count))
        else $error("count moved while paused");

    a_wrap_zero: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
        (tick && count == cnt_max && !run_start) |=> (count == '0))
        else $error("count did not wrap");

    a_match_a_req: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
        (match_a && mode != MODE_CAPTURE) |=> MATCH_A_REQ_O)
        else $error("comparator A request missing");

    a_clear_on_a: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
        (match_a && clr_a && !run_start) |=> (count == '0))
        else $error("count not cleared on A match");

    a_init_level: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
        s_run_rise |=> (out_level == $past(output_initial_level)))
        else $error("output not at initial level");

    a_high_read_latch: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
        rd_c_hi |=> (low_buffer == $past(count[7:0])))
        else $error("low byte not latched");

    a_low_write_buf: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
        (wr_a_lo) |=> (low_buffer == $past(DAT_I[7:0])) && $stable(match_a_value))
        else $error("low byte write leaked");

    a_match_p_req: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
        (match_p && !clr_a) |=> MATCH_P_REQ_O)
        else $error("comparator P request missing");

    a_no_p_on_a: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
        clr_a |=> !MATCH_P_REQ_O)
        else $error("comparator P request while clearing on A");

    a_clear_on_p: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
        (match_p && !clr_a && !run_start) |=> (count == '0))
        else $error("count not cleared on P match");

    a_tick_counts: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
        (tick && !clear_hit && !run_start) |=> (count == $past(count) + 1'b1))
        else $error("count did not advance on tick");

    a_compare_high: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
        (mode == MODE_COMPARE && match_a && !run_start && pin_action_select == ACT_HIGH)
        |=> out_level)
        else $error("output not driven high on match");

    a_capture_takes: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
        capture |=> (capture_value == $past(count)))
        else $error("capture value not taken");

    a_single_start: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
        (single && ck_rise && timer_run && !run_start) |=> pulse_active)
        else $error("single pulse not started");

    a_high_write: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
        wr_a_hi |=> (match_a_value == {$past(DAT_I[1:0]), $past(low_buffer)}))
        else $error("high byte write did not commit buffer");

endmodule

// File: test/pin_stimulus.sv
`timescale 1ns/10ps
// Outside world at the timer input pins; both pins idle low between bursts
module pin_stimulus (
    // Clock
    input  wire logic clk_i,
    // Pins
    output logic      ext_clock_pin_o,
    output logic      capture_pin_o
);
    initial begin
        ext_clock_pin_o = 1'b0;
        capture_pin_o   = 1'b0;
    end

    // Whole pulses on one pin, each level held for half cycles; always inputs
    task automatic pulses(input int which, input int n, input int half);
        int i;
        for (i = 0; i < 2 * n; i++) begin
            repeat (half) @(posedge clk_i);
            if (which == 0)
                ext_clock_pin_o <= ~ext_clock_pin_o;
            else
                capture_pin_o <= ~capture_pin_o;
        end
        repeat (half + 4) @(posedge clk_i);
    endtask
endmodule

// File: test/standard_timer_tb.sv
`timescale 1ns/10ps
module standard_timer_tb;
    import std_timer_pkg::*;

    typedef struct {
        logic [2:0] idx;
        logic       we;
        logic [7:0] wd;
        logic [7:0] exp;
    } row_s;

    logic        sys_clk   = 1'b0;
    logic        reset     = 1'b1;
    logic        cyc       = 1'b0;
    logic        stb       = 1'b0;
    logic        we        = 1'b0;
    logic [4:0]  adr       = 5'h00;
    logic [31:0] dat_w     = 32'h0;
    logic [31:0] dat_r;
    logic        ack;
    logic        err;
    logic        ext_pin;
    logic        cap_pin;
    logic        pin_out;
    logic [2:0]  pulse;
    logic [31:0] rd;
    logic        rd_err;
    logic [9:0]  v1;
    logic [9:0]  v2;
    int          ev [3]    = '{0, 0, 0};
    int          gap [3]   = '{0, 0, 0};
    int          last [3]  = '{0, 0, 0};
    int          cyc_cnt   = 0;
    int          error_cnt = 0;
    int          tests_run = 0;
    row_s        rows [16] = '{
        '{REG_CTRL_CLOCK_RUN, 1'b0, 8'h00, CTRL_RESET},
        '{REG_CTRL_MODE_OUTPUT, 1'b0, 8'h00, 8'h00},
        '{REG_COUNT_HIGH, 1'b0, 8'h00, 8'h00},
        '{REG_COUNT_LOW, 1'b0, 8'h00, 8'h00},
        '{REG_CTRL_CLOCK_RUN, 1'b1, 8'hF7, 8'h00},
        '{REG_CTRL_CLOCK_RUN, 1'b0, 8'h00, 8'hF7},
        '{REG_CTRL_CLOCK_RUN, 1'b1, 8'h00, 8'h00},
        '{REG_MATCH_A_HIGH, 1'b0, 8'h00, 8'h00},
        '{REG_MATCH_A_LOW, 1'b0, 8'h00, 8'h00},
        '{REG_MATCH_A_LOW, 1'b1, 8'hAB, 8'h00},
        '{REG_MATCH_A_HIGH, 1'b1, 8'hFF, 8'h00},
        '{REG_MATCH_A_HIGH, 1'b0, 8'h00, 8'h03},
        '{REG_MATCH_A_LOW, 1'b0, 8'h00, 8'hAB},
        '{REG_COUNT_LOW, 1'b1, 8'h55, 8'h00},
        '{REG_COUNT_HIGH, 1'b0, 8'h00, 8'h00},
        '{REG_COUNT_LOW, 1'b0, 8'h00, 8'h00}};

    always #12.5 sys_clk = ~sys_clk;

    standard_timer i_dut (
        .SYS_CLK_I         (sys_clk),
        .RESET_I           (reset),
        .CYC_I             (cyc),
        .STB_I             (stb),
        .WE_I              (we),
        .SEL_I             (4'hF),
        .ADR_I             (adr),
        .DAT_I             (dat_w),
        .DAT_O             (dat_r),
        .ACK_O             (ack),
        .ERR_O             (err),
        .H_CLK_TICK_I      (1'b0),
        .SUB_CLK_TICK_I    (1'b0),
        .EXT_CLOCK_PIN_I   (ext_pin),
        .CAPTURE_PIN_I     (cap_pin),
        .TIMER_OUTPUT_PIN_O(pin_out),
        .MATCH_A_REQ_O     (pulse[0]),
        .MATCH_P_REQ_O     (pulse[1]),
        .CAPTURE_EVENT_O   (pulse[2])
    );

    pin_stimulus i_pins (
        .clk_i          (sys_clk),
        .ext_clock_pin_o(ext_pin),
        .capture_pin_o  (cap_pin)
    );

    // Event counts and spacing in clock cycles
    always @(posedge sys_clk) begin
        cyc_cnt <= cyc_cnt + 1;
        for (int k = 0; k < 3; k++) begin
            if (pulse[k] === 1'b1) begin
                ev[k]   <= ev[k] + 1;
                gap[k]  <= cyc_cnt - last[k];
                last[k] <= cyc_cnt;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic fail_wait();
        error_cnt++;
        $display("ERROR at %0t: wait ran out, got %0h expected %0h", $time, 0, 1);
        test_done();
    endtask

    task automatic wb(input logic [2:0] idx, input logic w, input logic [7:0] wd);
        int n;
        @(posedge sys_clk);
        cyc   <= 1'b1;
        stb   <= 1'b1;
        we    <= w;
        adr   <= {idx, 2'b00};
        dat_w <= {24'h0, wd};
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (ack !== 1'b1 && err !== 1'b1 && n < 16);
        if (ack !== 1'b1 && err !== 1'b1)
            fail_wait();
        rd = dat_r;
        rd_err = err;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic read_count(output logic [9:0] v);
        wb(REG_COUNT_HIGH, 1'b0, 8'h00);
        v[9:8] = rd[1:0];
        wb(REG_COUNT_LOW, 1'b0, 8'h00);
        v[7:0] = rd[7:0];
    endtask

    task automatic run(input logic [7:0] c1, input logic [7:0] c0);
        wb(REG_CTRL_CLOCK_RUN, 1'b1, c0 & 8'hF7);
        wb(REG_CTRL_MODE_OUTPUT, 1'b1, c1);
        wb(REG_CTRL_CLOCK_RUN, 1'b1, c0);
    endtask

    task automatic wait_ev(input int w, input int n);
        int t;
        int k;
        t = ev[w] + n;
        for (k = 0; k < 3000 && ev[w] < t; k++)
            @(posedge sys_clk);
        if (ev[w] < t)
            fail_wait();
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        int e;
        repeat (5) @(posedge sys_clk);
        reset <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            wb(rows[i].idx, rows[i].we, rows[i].wd);
            if (rows[i].we === 1'b0)
                chk(rd, {24'h0, rows[i].exp});
        end
        wb(3'h7, 1'b0, 8'h00);
        chk({31'h0, rd_err}, 32'h1);
        // Match A at 5 clears the count, toggle on every match
        wb(REG_MATCH_A_LOW, 1'b1, 8'h05);
        wb(REG_MATCH_A_HIGH, 1'b1, 8'h00);
        e = ev[1];
        run(8'h31, 8'h18);
        wait_ev(0, 3);
        chk(gap[0], 6);
        chk(ev[1] - e, 0);
        for (int k = 0; k < 3; k++) begin
            run({2'b00, k[1:0], k != 2, 3'b001}, 8'h18);
            repeat (2) @(posedge sys_clk);
            chk(pin_out, k != 2);
            wait_ev(0, 1);
            repeat (2) @(posedge sys_clk);
            chk(pin_out, k != 1);
        end
        for (int k = 0; k < 8; k++) begin
            run(8'h00, {5'b00011, k[2:0]});
            wait_ev(1, 2);
            chk(gap[1], (k == 0) ? 1024 : k * 128);
        end
        run(8'h00, 8'h18);
        repeat (50) @(posedge sys_clk);
        wb(REG_CTRL_CLOCK_RUN, 1'b1, 8'h98);
        read_count(v1);
        repeat (20) @(posedge sys_clk);
        read_count(v2);
        chk(v2, v1);
        wb(REG_CTRL_CLOCK_RUN, 1'b1, 8'h18);
        repeat (20) @(posedge sys_clk);
        read_count(v2);
        chk(v2 > v1, 1);
        wb(REG_CTRL_CLOCK_RUN, 1'b1, 8'h10);
        read_count(v1);
        repeat (20) @(posedge sys_clk);
        read_count(v2);
        chk(v2, v1);
        wb(REG_CTRL_CLOCK_RUN, 1'b1, 8'h18);
        read_count(v2);
        chk(v2 < 10'd16, 1);
        run(8'h00, 8'h68);
        i_pins.pulses(0, 7, 4);
        read_count(v1);
        chk(v1, 7);
        run(8'h00, 8'h78);
        i_pins.pulses(0, 5, 6);
        read_count(v1);
        chk(v1, 5);
        for (int k = 0; k < 3; k++) begin
            run({2'b01, k[1:0], 4'h0}, 8'h18);
            e = ev[2];
            i_pins.pulses(1, 3, 4);
            chk(ev[2] - e, (k == 2) ? 6 : 3);
        end
        // Quarter system clock source
        run(8'h00, 8'h08);
        repeat (40) @(posedge sys_clk);
        read_count(v1);
        chk(v1 >= 10'd9 && v1 <= 10'd12, 1);
        // PWM output: initial level while count is below match A
        run(8'hA8, 8'h18);
        repeat (2) @(posedge sys_clk);
        chk(pin_out, 1'b1);
        repeat (20) @(posedge sys_clk);
        chk(pin_out, 1'b0);
        // Single pulse: clock pin rise starts, match A ends
        run(8'hB8, 8'h18);
        i_pins.pulses(0, 1, 4);
        chk(pin_out, 1'b1);
        wait_ev(0, 1);
        repeat (2) @(posedge sys_clk);
        chk(pin_out, 1'b0);
        @(posedge sys_clk);
        reset <= 1'b1;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        wb(REG_CTRL_CLOCK_RUN, 1'b0, 8'h00);
        chk(rd, {24'h0, CTRL_RESET});
        test_done();
    end
endmodule
